// ===== hw/fps_pwm_ctrl.sv
// Startup sequencing, soft start and cycle-by-cycle PWM of the flyback controller
`timescale 1ns/1ps
module fps_pwm_ctrl #(
  parameter int unsigned SS_STEP_CYC = fps_pkg::SS_STEP_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic supply_above_short_i,
  input wire logic supply_above_on_i,
  input wire logic supply_above_off_i,
  input wire logic supply_above_ovp_i,
  input wire logic pwm_cmp_i,
  input wire logic cs_limit_cmp_i,
  input wire logic line_overvoltage_stop_i,
  input wire logic freq_reduce_i,
  input wire logic option_100k_i,
  output logic gate_o,
  output logic precharge_step_one_o,
  output logic precharge_step_two_o,
  output logic [9:0] cs_limit_mv_o,
  output logic soft_start_done_o,
  output logic jitter_enable_o,
  output logic operating_o
);
  import fps_pkg::*;

  // ==========================================================
  // Input synchronisation
  fps_cmp_if cmp ();
  logic [NUM_IN-1:0] raw;
  assign raw = {option_100k_i, freq_reduce_i, line_overvoltage_stop_i, cs_limit_cmp_i,
                pwm_cmp_i, supply_above_ovp_i, supply_above_off_i, supply_above_on_i,
                supply_above_short_i};

  fps_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .raw_i(raw),
    .cmp(cmp.src)
  );

  logic s_scp;
  logic s_on;
  logic s_off;
  logic s_ovp;
  logic s_pwm;
  logic s_cslim;
  logic s_line_overvoltage_stop;
  logic s_fred;
  logic s_opt;
  assign s_scp = cmp.level[IN_SCP];
  assign s_on = cmp.level[IN_ON];
  assign s_off = cmp.level[IN_OFF];
  assign s_ovp = cmp.level[IN_OVP];
  assign s_pwm = cmp.level[IN_PWM];
  assign s_cslim = cmp.level[IN_CSLIM];
  assign s_line_overvoltage_stop = cmp.level[IN_LINE_OVERVOLTAGE_STOP];
  assign s_fred = cmp.level[IN_FRED];
  assign s_opt = cmp.level[IN_OPT];

  // ==========================================================
  // Supply sequencing
  fps_state_t state_q;
  fps_state_t state_d;
  logic window_ok;
  logic ss_done_q;
  assign window_ok = s_off && !s_ovp;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_PRECH_ONE: begin
        if (s_scp) begin
          state_d = ST_PRECH_TWO;
        end
      end
      ST_PRECH_TWO: begin
        if (!s_scp) begin
          state_d = ST_PRECH_ONE;
        end else if (s_on && window_ok) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (!window_ok) begin
          state_d = ST_PRECH_ONE;
        end else if (ss_done_q) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        if (!window_ok) begin
          state_d = ST_PRECH_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_PRECH_ONE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      precharge_step_one_o <= 1'b1;
      precharge_step_two_o <= 1'b0;
      operating_o <= 1'b0;
    end else begin
      precharge_step_one_o <= (state_d == ST_PRECH_ONE);
      precharge_step_two_o <= (state_d == ST_PRECH_TWO);
      operating_o <= (state_d == ST_SOFT) || (state_d == ST_RUN);
    end
  end

  // ==========================================================
  // Soft start timer and limit steps
  logic [SS_CNT_W-1:0] ss_cnt_q;
  logic [1:0] ss_step_q;
  logic in_soft;
  assign in_soft = (state_q == ST_SOFT);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_cnt_q <= '0;
      ss_step_q <= '0;
      ss_done_q <= 1'b0;
    end else if (!in_soft && state_q != ST_RUN) begin
      ss_cnt_q <= '0;
      ss_step_q <= '0;
      ss_done_q <= 1'b0;
    end else if (in_soft && !ss_done_q) begin
      if (ss_cnt_q == SS_CNT_W'(SS_STEP_CYC - 1)) begin
        ss_cnt_q <= '0;
        if (ss_step_q == SS_LAST_STEP) begin
          ss_done_q <= 1'b1;
        end else begin
          ss_step_q <= ss_step_q + 2'h1;
        end
      end else begin
        ss_cnt_q <= ss_cnt_q + SS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_limit_mv_o <= CS_LIM_START_MV;
      soft_start_done_o <= 1'b0;
    end else begin
      if (ss_step_q == SS_LAST_STEP) begin
        cs_limit_mv_o <= CS_LIM_FINAL_MV;
      end else begin
        cs_limit_mv_o <= CS_LIM_START_MV + 10'(ss_step_q) * CS_LIM_INC_MV;
      end
      soft_start_done_o <= ss_done_q;
    end
  end

  // ==========================================================
  // Oscillator with jitter
  logic [PER_W-1:0] ph_q;
  logic [PER_W-1:0] per_q;
  logic [PER_W-1:0] per_d;
  logic [PER_W-1:0] base_per;
  logic [PER_W-1:0] jit_q;
  logic jit_up_q;
  logic cyc_start;
  logic jit_on;
  assign jit_on = ss_done_q && (state_q == ST_RUN);
  assign cyc_start = (ph_q == per_q - PER_W'(1));
  assign base_per = s_opt ? PER_100K : PER_65K;
  // Light feedback doubles the period; jitter rides on top
  assign per_d = (s_fred ? {base_per[PER_W-2:0], 1'b0} : base_per) - JIT_MAX
                 + (jit_on ? jit_q : JIT_MAX);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= '0;
      per_q <= PER_65K;
    end else if (cyc_start) begin
      ph_q <= '0;
      per_q <= per_d;
    end else begin
      ph_q <= ph_q + PER_W'(1);
    end
  end

  // Triangle offset 0..2*JIT_MAX, one step per period
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jit_q <= JIT_MAX;
      jit_up_q <= 1'b1;
    end else if (!jit_on) begin
      jit_q <= JIT_MAX;
      jit_up_q <= 1'b1;
    end else if (cyc_start) begin
      if (jit_up_q && jit_q == {JIT_MAX[PER_W-2:0], 1'b0}) begin
        jit_up_q <= 1'b0;
        jit_q <= jit_q - PER_W'(1);
      end else if (!jit_up_q && jit_q == '0) begin
        jit_up_q <= 1'b1;
        jit_q <= jit_q + PER_W'(1);
      end else begin
        jit_q <= jit_up_q ? jit_q + PER_W'(1) : jit_q - PER_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jitter_enable_o <= 1'b0;
    end else begin
      jitter_enable_o <= jit_on;
    end
  end

  // ==========================================================
  // Gate on/off decision
  logic [3:0] on_cnt_q;
  logic leb_done;
  logic max_on;
  logic may_switch;
  logic cs_off;
  logic gate_off;
  assign leb_done = (on_cnt_q >= LEB_CYC);
  assign max_on = (ph_q >= per_q - {2'b00, per_q[PER_W-1:2]});
  assign may_switch = (in_soft || state_q == ST_RUN) && window_ok && !s_line_overvoltage_stop;
  // Soft start limit matters only until its last step is done
  assign cs_off = s_pwm || (s_cslim && !ss_done_q);
  assign gate_off = (leb_done && cs_off) || max_on || !may_switch;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_o <= 1'b0;
    end else if (gate_o && gate_off) begin
      gate_o <= 1'b0;
    end else if (cyc_start && may_switch) begin
      gate_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt_q <= '0;
    end else if (!gate_o) begin
      on_cnt_q <= '0;
    end else if (!leb_done) begin
      on_cnt_q <= on_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // Checks
  sequence seq_turn_on;
    cyc_start && may_switch && !gate_o;
  endsequence
  sequence seq_blank;
    gate_o [*5];
  endsequence

  a_leb_min_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_turn_on ##1 gate_o |-> seq_blank or (gate_o ##[0:4] !may_switch))
    else $error("gate pulse shorter than blanking");
  a_turn_on_sync: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(gate_o) |-> $past(cyc_start))
    else $error("gate rose off oscillator edge");
  a_pwm_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_o && leb_done && s_pwm |=> !gate_o)
    else $error("gate stayed on after pwm trip");
  a_max_duty_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_o && max_on |=> !gate_o)
    else $error("gate beyond max duty");
  a_line_overvoltage_stop_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_line_overvoltage_stop |=> !gate_o)
    else $error("switching during line overvoltage");
  a_window_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (in_soft || state_q == ST_RUN) && !window_ok |=> state_q == ST_PRECH_ONE ##1 !operating_o)
    else $error("operation outside supply window");
  a_prech_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_PRECH_ONE && s_scp |=> state_q == ST_PRECH_TWO ##0 precharge_step_two_o)
    else $error("precharge step two not taken");
  a_turn_on_soft: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_PRECH_TWO && s_scp && s_on && window_ok
    |=> in_soft && !ss_done_q && ss_step_q == 2'h0)
    else $error("turn-on did not start soft start");
  a_ss_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    in_soft && !ss_done_q && ss_cnt_q == SS_CNT_W'(SS_STEP_CYC - 1) && ss_step_q != SS_LAST_STEP
    |=> ss_step_q == $past(ss_step_q) + 2'h1 ##1 cs_limit_mv_o > $past(cs_limit_mv_o))
    else $error("soft start step not advanced");
  a_jitter_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    jitter_enable_o |-> soft_start_done_o)
    else $error("jitter before soft start end");
  a_blank_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_o && !leb_done && may_switch && !max_on |=> gate_o)
    else $error("comparator acted inside blanking");
  a_soft_limit_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_o && leb_done && s_cslim && !ss_done_q |=> !gate_o)
    else $error("gate stayed on past soft start limit");
  a_prech_back: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_PRECH_TWO && !s_scp |=> precharge_step_one_o && !precharge_step_two_o)
    else $error("short-detect loss did not restore step one");
  a_no_turn_on_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_PRECH_TWO && !window_ok |=> !in_soft && !operating_o)
    else $error("soft start entered outside supply window");
endmodule : fps_pwm_ctrl

// ===== hw/fps_pkg.sv
// Constants and types shared by the flyback PWM soft-start controller
// How it works
// - While the supply is below the short-detect level the controller selects the tiny first charge current.
// - Above the short-detect level it selects the second charge current until the turn-on level is passed.
// - Passing the turn-on level starts switching, beginning with soft start.
// - Operation is allowed only between the undervoltage-off and supply overvoltage levels.
// - Soft start is a timed sequence of 12 ms in four steps.
// - The current-sense peak limit rises each step from 0.3 V to the final 0.8 V.
// - After soft start the soft start limit no longer acts; the feedback comparator or max duty sets the switch-off point.
// - Every turn-on is aligned to the oscillator, whose period follows the feedback level.
// - The gate goes off as soon as the scaled current sense passes the feedback voltage.
// - The current-sense comparators are ignored for a blanking time after each turn-on.
// - The gate is forced off when the on-time reaches 0.75 of the period.
// - A line overvoltage stops switching.
// - The oscillator runs at 65 kHz or 100 kHz by option, with periodic frequency variation.
// - Frequency variation is enabled only after soft start has completed.
package fps_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OSC_65K_HZ = 65_000;
  localparam int unsigned OSC_100K_HZ = 100_000;
  localparam int unsigned PER_W = 11;
  localparam logic [PER_W-1:0] PER_65K = PER_W'(CLK_HZ / OSC_65K_HZ);
  localparam logic [PER_W-1:0] PER_100K = PER_W'(CLK_HZ / OSC_100K_HZ);
  // Blanking time has no printed value; plain default
  localparam int unsigned LEB_NS = 200;
  localparam int unsigned LEB_CYC_I = (LEB_NS * (CLK_HZ / 1000) + 999_999) / 1_000_000;
  localparam logic [3:0] LEB_CYC = 4'(LEB_CYC_I);
  localparam int unsigned SS_MS = 12;
  localparam int unsigned SS_STEPS = 4;
  localparam int unsigned SS_CYC = SS_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_STEP_CYC_DEF = SS_CYC / SS_STEPS;
  localparam int unsigned SS_CNT_W = 24;
  // Jitter: +-4 percent of the 65 kHz period
  localparam int unsigned JIT_PCT = 4;
  localparam logic [PER_W-1:0] JIT_MAX = PER_W'((CLK_HZ / OSC_65K_HZ) * JIT_PCT / 100);
  // ==========================================================
  // Current-sense limit levels in millivolts
  localparam logic [9:0] CS_LIM_START_MV = 10'h12c;
  localparam logic [9:0] CS_LIM_FINAL_MV = 10'h320;
  localparam logic [9:0] CS_LIM_INC_MV = (CS_LIM_FINAL_MV - CS_LIM_START_MV) / 10'h3;
  localparam logic [1:0] SS_LAST_STEP = 2'h3;
  // ==========================================================
  // Synchronised comparator inputs
  localparam int unsigned IN_SCP = 0;
  localparam int unsigned IN_ON = 1;
  localparam int unsigned IN_OFF = 2;
  localparam int unsigned IN_OVP = 3;
  localparam int unsigned IN_PWM = 4;
  localparam int unsigned IN_CSLIM = 5;
  localparam int unsigned IN_LINE_OVERVOLTAGE_STOP = 6;
  localparam int unsigned IN_FRED = 7;
  localparam int unsigned IN_OPT = 8;
  localparam int unsigned NUM_IN = 9;

  typedef enum logic [1:0] {
    ST_PRECH_ONE = 2'b00,
    ST_PRECH_TWO = 2'b01,
    ST_SOFT = 2'b10,
    ST_RUN = 2'b11
  } fps_state_t;
endpackage : fps_pkg

// ===== hw/fps_cmp_if.sv
// Interface carrying synchronised comparator levels
`timescale 1ns/1ps
interface fps_cmp_if;
  logic [fps_pkg::NUM_IN-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : fps_cmp_if

// ===== hw/fps_sync.sv
// Three-stage synchroniser for asynchronous comparator outputs
`timescale 1ns/1ps
module fps_sync (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [fps_pkg::NUM_IN-1:0] raw_i,
  fps_cmp_if.src cmp
);
  import fps_pkg::*;
  logic [NUM_IN-1:0] ff1_q;
  logic [NUM_IN-1:0] ff2_q;
  logic [NUM_IN-1:0] ff3_q;
  logic [NUM_IN-1:0] lvl_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
    end else begin
      ff1_q <= raw_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // A bit moves only once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= (ff2_q & ~(ff2_q ^ ff3_q)) | (lvl_q & (ff2_q ^ ff3_q));
    end
  end

  assign cmp.level = lvl_q;
endmodule : fps_sync

// ===== testbench/fps_switch_model.sv
// Power switch and sense resistor model feeding the current comparators
`timescale 1ns/1ps
module fps_switch_model (
  input wire logic clk_sys_i,
  input wire logic gate_i,
  input wire logic [9:0] cs_limit_mv_i,
  input wire logic [9:0] fb_mv_i,
  input wire logic [3:0] ramp_i,
  output logic pwm_cmp_o,
  output logic cs_limit_cmp_o,
  output logic [10:0] peak_mv_o
);
  logic [10:0] cur_mv = '0;
  logic on_q = 1'b0;
  // ==========================================================
  // Current ramp
  // Ramp advances off the sampling edge, like an analog comparator output
  always @(negedge clk_sys_i) begin
    on_q <= gate_i;
    cur_mv <= gate_i ? cur_mv + 11'(ramp_i) : '0;
  end
  // No current while the switch is off, so both comparators stay low
  assign pwm_cmp_o = on_q && (cur_mv >= {1'b0, fb_mv_i});
  assign cs_limit_cmp_o = on_q && (cur_mv >= {1'b0, cs_limit_mv_i});
  assign peak_mv_o = cur_mv;
endmodule : fps_switch_model

// ===== testbench/flyback_pwm_softstart_control_bench.sv
// Self-checking bench for the flyback PWM soft-start controller
`timescale 1ns/1ps
module flyback_pwm_softstart_control_bench;
  import fps_pkg::*;
  // Short steps keep the run brief but span several switching periods
  localparam int SS = 1000;
  localparam int LIMIT = 60000;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sh = 0, on = 0, off = 0, ovp = 0, line_overvoltage_stop = 0, fred = 0, opt = 0;
  logic pwm, csl, gate, st1, st2, done, jit, op;
  logic [9:0] cs_mv;
  logic [9:0] fb_mv = 10'h3ff;
  logic [3:0] ramp = 4'h4;
  logic [10:0] peak;
  int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 32'h153f;
  int n_rise = 0, t_rise = 0, width = 0, period = 0, t_step = 0, n_step = 0, k = 0;
  logic gate_p = 0, cs_watch = 0, per_chk = 0, peak_chk = 0;
  logic [9:0] cs_p = 10'h12c;
  logic [9:0] lim_t = 10'h12c;
  logic [9:0] cs_q[$];

  always #20 clk_sys_i = ~clk_sys_i;

  fps_pwm_ctrl #(.SS_STEP_CYC(SS)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .supply_above_short_i(sh),
    .supply_above_on_i(on), .supply_above_off_i(off), .supply_above_ovp_i(ovp),
    .pwm_cmp_i(pwm), .cs_limit_cmp_i(csl), .line_overvoltage_stop_i(line_overvoltage_stop),
    .freq_reduce_i(fred), .option_100k_i(opt), .gate_o(gate),
    .precharge_step_one_o(st1), .precharge_step_two_o(st2), .cs_limit_mv_o(cs_mv),
    .soft_start_done_o(done), .jitter_enable_o(jit), .operating_o(op)
  );

  fps_switch_model sw_u (
    .clk_sys_i(clk_sys_i), .gate_i(gate), .cs_limit_mv_i(cs_mv), .fb_mv_i(fb_mv),
    .ramp_i(ramp), .pwm_cmp_o(pwm), .cs_limit_cmp_o(csl), .peak_mv_o(peak)
  );

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  task automatic wait_op(input logic v);
    for (int i = 0; i < 16 && op !== v; i++) @(negedge clk_sys_i);
    chk(op, v);
  endtask : wait_op

  // Waits for a pulse that began wholly after the caller's settings
  task automatic next_pulse();
    int j;
    j = n_rise + 1;
    for (int i = 0; i < 3000 && (n_rise <= j || gate); i++) @(negedge clk_sys_i);
  endtask : next_pulse

  // ==========================================================
  // Output watcher: pulses, soft start steps, timeout
  always @(negedge clk_sys_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      conclude();
    end
    if (!csl) lim_t = cs_mv;
    if (gate && !gate_p) begin
      period = cyc - t_rise;
      if (per_chk && n_rise > 0) chk(period, 32'(PER_65K));
      if (!done) chk(jit, 1'b0);
      n_rise++;
      t_rise = cyc;
    end
    if (!gate && gate_p) begin
      width = cyc - t_rise;
      if (peak_chk && !done) chk(peak >= lim_t && peak <= lim_t + 40, 1'b1);
    end
    gate_p = gate;
    if (cs_watch && cs_mv !== cs_p) begin
      chk(cs_mv, cs_q.pop_front());
      if (n_step > 0) chk(cyc - t_step, SS);
      n_step++;
      t_step = cyc;
      cs_p = cs_mv;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys_i);
    chk({gate, st1, st2, done, jit, op}, 6'b010000);
    chk(cs_mv, CS_LIM_START_MV);
    rst_n_i = 1'b1;
    off = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk({st1, st2, op}, 3'b100);
    sh = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk({st1, st2, op}, 3'b010);
    sh = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    chk({st1, st2}, 2'b10);
    sh = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    endt("precharge");
    cs_q = '{10'h1d2, 10'h278, CS_LIM_FINAL_MV};
    cs_watch = 1'b1;
    per_chk = 1'b1;
    peak_chk = 1'b1;
    on = 1'b1;
    wait_op(1'b1);
    t_step = cyc;
    k = cyc;
    for (int i = 0; i < 4 * SS + 20 && !done; i++) @(negedge clk_sys_i);
    chk(cyc - k >= 4 * SS && cyc - k <= 4 * SS + 3, 1'b1);
    chk(cs_q.size(), 0);
    repeat (3) @(negedge clk_sys_i);
    chk(jit, 1'b1);
    cs_watch = 1'b0;
    per_chk = 1'b0;
    peak_chk = 1'b0;
    endt("soft start");
    // Slow ramp: the old soft limit is crossed, max duty must end the pulse
    ramp = 4'h3;
    next_pulse();
    chk(width >= 274 && width <= 302, 1'b1);
    ramp = 4'h2;
    for (int n = 0; n < 4; n++) begin
      fb_mv = 10'(40 + ($random(seed) & 32'h7f));
      next_pulse();
      chk(width >= fb_mv / 2 + 1 && width <= fb_mv / 2 + 10, 1'b1);
    end
    fb_mv = 10'h000;
    next_pulse();
    chk(width >= int'(LEB_CYC) && width <= 12, 1'b1);
    endt("switch off");
    fb_mv = 10'h3ff;
    ramp = 4'h1;
    opt = 1'b1;
    next_pulse();
    chk(period >= 235 && period <= 265, 1'b1);
    chk(width >= 174 && width <= 201, 1'b1);
    fred = 1'b1;
    next_pulse();
    next_pulse();
    chk(period >= 470 && period <= 530, 1'b1);
    opt = 1'b0;
    fred = 1'b0;
    endt("oscillator");
    line_overvoltage_stop = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    k = n_rise;
    repeat (1000) @(negedge clk_sys_i);
    chk(n_rise - k, 0);
    chk({gate, op}, 2'b01);
    line_overvoltage_stop = 1'b0;
    next_pulse();
    chk(n_rise > k, 1'b1);
    endt("line overvoltage");
    ovp = 1'b1;
    wait_op(1'b0);
    k = n_rise;
    repeat (800) @(negedge clk_sys_i);
    chk(n_rise - k, 0);
    chk(gate, 1'b0);
    chk(op, 1'b0);
    ovp = 1'b0;
    wait_op(1'b1);
    off = 1'b0;
    wait_op(1'b0);
    repeat (2) @(negedge clk_sys_i);
    chk(gate, 1'b0);
    endt("supply window");
    conclude();
  end
endmodule : flyback_pwm_softstart_control_bench
